// ===== fwsr_bus_cycle.sv
// One strobed read or write cycle on the flash parallel bus
`timescale 1ns/1ps
`include "fwsr_defines.svh"
module fwsr_bus_cycle (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        start_in,
	input  wire logic        write_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic [7:0]  dq_in,
	output logic             done_out,
	output logic [7:0]       rdata_out,
	output logic             ce_n_out,
	output logic             oe_n_out,
	output logic             we_n_out,
	output logic [7:0]       dq_out,
	output logic             dq_oe_out
);
	typedef struct packed {
		logic       busy;
		logic       wr;
		logic [3:0] cnt;
		logic [7:0] rd;
		logic       done;
		logic [7:0] wd;
	} fwsr_cyc_t;
	fwsr_cyc_t c_r;
	fwsr_cyc_t c_nxt;
	localparam logic [3:0] STROBE_LEN = 4'(`FWSR_STROBE_CYC);
	always_comb begin
		c_nxt      = c_r;
		c_nxt.done = 1'b0;
		if (!c_r.busy && start_in) begin
			c_nxt.busy = 1'b1;
			c_nxt.wr   = write_in;
			c_nxt.wd   = wdata_in;
			c_nxt.cnt  = STROBE_LEN;
		end else if (c_r.busy) begin
			if (c_r.cnt == 4'h0) begin
				// Sample at strobe end, then release CE# and OE# so every read is a separate strobe
				c_nxt.busy = 1'b0;
				c_nxt.done = 1'b1;
				if (!c_r.wr) begin
					c_nxt.rd = dq_in;
				end
			end else begin
				c_nxt.cnt = c_r.cnt - 4'h1;
			end
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			c_r <= '0;
		end else begin
			c_r <= c_nxt;
		end
	end
	// Both CE# and OE# strobe each read; the device toggles on either RQ8
	assign ce_n_out  = !c_r.busy;
	assign oe_n_out  = !(c_r.busy && !c_r.wr);
	assign we_n_out  = !(c_r.busy && c_r.wr && c_r.cnt != 4'h0);
	assign dq_out    = c_r.wd;
	assign dq_oe_out = c_r.busy && c_r.wr;
	assign done_out  = c_r.done;
	assign rdata_out = c_r.rd;
endmodule : fwsr_bus_cycle

// ===== fwsr_defines.svh
// Register offsets, field positions and timing counts of the status poller
`ifndef FWSR_DEFINES_SVH
`define FWSR_DEFINES_SVH
`define FWSR_REG_CTRL        8'h00
`define FWSR_REG_ADDR        8'h04
`define FWSR_REG_DATA        8'h08
`define FWSR_REG_STATUS      8'h0C
`define FWSR_REG_LAST        8'h10
`define FWSR_CTRL_GO_BIT     0
`define FWSR_CTRL_POLL_BIT   1
`define FWSR_CTRL_WRITE_BIT  2
`define FWSR_CTRL_RESET_BIT  3
`define FWSR_BIT_POLL        7
`define FWSR_BIT_TOG1        6
`define FWSR_BIT_ERR         5
`define FWSR_BIT_STARTED     3
`define FWSR_BIT_TOG2        2
`define FWSR_RESET_CMD       8'hF0
`define FWSR_STROBE_NS       100
`define FWSR_CLK_NS          25
`define FWSR_STROBE_CYC      ((`FWSR_STROBE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_RESP_OKAY       2'b00
`define FWSR_RESP_SLVERR     2'b10
`endif

// ===== fwsr_flash_model.sv
// Behavioural flash device answering status reads
`timescale 1ns/1ps
module fwsr_flash_model (
	input  wire logic       ce_n_in,
	input  wire logic       oe_n_in,
	input  wire logic       we_n_in,
	input  wire logic [7:0] dq_in,
	output logic [7:0]      dq_out,
	output logic            ready_busy_n_out
);
	// Modes: 0 array, 1 program, 2 erase, 3 failed erase
	int         mode = 0, busy_left = 0, resets = 0;
	logic [7:0] array_q = 8'h5A, held = 8'h00, last_w = 8'h00, stat;
	logic       tog1 = 1'b0, tog2 = 1'b0;
	wire        rd = !ce_n_in && !oe_n_in;
	always_comb begin
		stat = {1'b0, tog1, mode == 3, 2'b01, tog2, 2'b00};
		if (mode == 1)
			stat = {~array_q[7], tog1, 1'b0, array_q[4:0]};
	end
	// Released bus shows the inverse, not a stale value
	assign dq_out = !rd ? ~held : (mode == 0 ? array_q : stat);
	assign ready_busy_n_out = (mode == 0);
	always @(posedge (ce_n_in | oe_n_in)) begin
		held = (mode == 0) ? array_q : stat;
		if (mode != 0) begin
			tog1 = ~tog1;
			tog2 = ~tog2;
		end
		if (mode == 1 || mode == 2) begin
			if (busy_left == 0)
				mode = 0;
			else
				busy_left--;
		end
	end
	always @(posedge we_n_in) begin
		if (ce_n_in === 1'b0) begin
			last_w = dq_in;
			if (dq_in == 8'hF0 && mode != 2) begin
				resets++;
				mode = 0;
			end else if (mode == 0) begin
				array_q = dq_in;
				mode = 1;
				busy_left = 3;
			end
		end
	end
endmodule : fwsr_flash_model

// ===== fwsr_host.sv
// Host-side write-status poller for a parallel flash, with AXI4-Lite control
// Notes on behaviour
// RQ1: Erase-started bit goes 1 when erase begins
// RQ2: Erase-started reads 1 right after confirm
// RQ3: Erase-started bit ignored for chip erase
// RQ4: Started bit 0 means timeout window open
// RQ5: After erase start only suspend accepted
// RQ6: Sector toggle alternates in selected sectors
// RQ7: Sector toggle valid after last write strobe
// RQ8: Toggle advances on OE or CE reads
// RQ9: Sector toggle does not show suspend
// RQ10: Toggle one shows active versus suspended
// RQ11: Unselected sector reads true data suspended
// RQ12: Toggle one alternates while busy, else steady
// RQ13: Poll bit 0 erasing, 1 when done
// RQ14: Error bit 1 on failure
// RQ15: Error bit 0 during normal operation
// RQ16: Host reads status twice before deciding
// RQ17: Unchanged toggle means done, data follows
// RQ18: Toggling with error set: reread twice
// RQ19: Still toggling after error: fail, reset
// RQ20: Resumed polling restarts from double read
// RQ21: Poll bit complements data while programming
// RQ22: Ready/busy low while programming or erasing
// RQ23: Program: no sector toggle, started undefined
// RQ24: Unaffected reads return array data
`timescale 1ns/1ps
`include "fwsr_defines.svh"
module fwsr_host (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic [19:0]      flash_addr_out,
	output logic             ce_n_out,
	output logic             oe_n_out,
	output logic             we_n_out,
	input  wire logic [7:0]  dq_in,
	output logic [7:0]       dq_out,
	output logic             dq_oe_out,
	input  wire logic        ready_busy_n_in
);
	typedef struct packed {
		fwsr_pkg::fwsr_state_t  st;
		fwsr_pkg::fwsr_result_t res;
		logic [19:0]            addr;
		logic [7:0]             wdata;
		logic                   go;
		logic                   want_write;
		logic [7:0]             first;
		logic [7:0]             last;
		logic                   err_seen;
		logic                   aw_got;
		logic                   w_got;
		logic [7:0]             aw_addr;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} fwsr_host_t;
	fwsr_host_t h_r;
	fwsr_host_t h_nxt;
	logic       cyc_start;
	logic       cyc_write;
	logic [7:0] cyc_wdata;
	logic       cyc_done;
	logic [7:0] cyc_rdata;
	logic       rb_level;
	logic [7:0] toggled;
	fwsr_bus_cycle u_cycle (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.start_in  (cyc_start),
		.write_in  (cyc_write),
		.wdata_in  (cyc_wdata),
		.dq_in     (dq_in),
		.done_out  (cyc_done),
		.rdata_out (cyc_rdata),
		.ce_n_out  (ce_n_out),
		.oe_n_out  (oe_n_out),
		.we_n_out  (we_n_out),
		.dq_out    (dq_out),
		.dq_oe_out (dq_oe_out)
	);
	// Open-drain busy line from the device passes the pin synchroniser
	fwsr_sync u_rb_sync (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.async_in  (ready_busy_n_in),
		.level_out (rb_level)
	);
	assign toggled = h_r.first ^ cyc_rdata;
	always_comb begin
		h_nxt     = h_r;
		cyc_start = 1'b0;
		cyc_write = 1'b0;
		cyc_wdata = h_r.wdata;
		// Register write: take AW and W in either order
		if (!h_r.aw_got && s_axi_awvalid_in) begin
			h_nxt.aw_got  = 1'b1;
			h_nxt.aw_addr = s_axi_awaddr_in;
		end
		if (!h_r.w_got && s_axi_wvalid_in) begin
			h_nxt.w_got  = 1'b1;
			h_nxt.w_data = s_axi_wdata_in;
			h_nxt.w_strb = s_axi_wstrb_in;
		end
		if (h_r.aw_got && h_r.w_got && !h_r.bvalid) begin
			h_nxt.aw_got = 1'b0;
			h_nxt.w_got  = 1'b0;
			h_nxt.bvalid = 1'b1;
			h_nxt.bresp  = `FWSR_RESP_OKAY;
			unique case (h_r.aw_addr)
				`FWSR_REG_CTRL: begin
					if (h_r.w_strb[0] && h_r.st == fwsr_pkg::ST_IDLE) begin
						h_nxt.go         = h_r.w_data[`FWSR_CTRL_GO_BIT];
						h_nxt.want_write = h_r.w_data[`FWSR_CTRL_WRITE_BIT];
						if (h_r.w_data[`FWSR_CTRL_RESET_BIT]) begin
							h_nxt.wdata      = `FWSR_RESET_CMD;
							h_nxt.want_write = 1'b1;
						end
						if (h_r.w_data[`FWSR_CTRL_POLL_BIT]) begin
							h_nxt.res = fwsr_pkg::RES_BUSY;
						end
					end
				end
				`FWSR_REG_ADDR: begin
					h_nxt.addr = h_r.w_data[19:0];
				end
				`FWSR_REG_DATA: begin
					if (h_r.w_strb[0]) begin
						h_nxt.wdata = h_r.w_data[7:0];
					end
				end
				default: begin
					h_nxt.bresp = `FWSR_RESP_SLVERR;
				end
			endcase
		end
		if (h_r.bvalid && s_axi_bready_in) begin
			h_nxt.bvalid = 1'b0;
		end
		// Register read, one cycle after the address is taken
		if (s_axi_arvalid_in && !h_r.rvalid) begin
			h_nxt.rvalid = 1'b1;
			h_nxt.rresp  = `FWSR_RESP_OKAY;
			unique case (s_axi_araddr_in)
				`FWSR_REG_CTRL:   h_nxt.rdata = {31'h0, h_r.st != fwsr_pkg::ST_IDLE};
				`FWSR_REG_ADDR:   h_nxt.rdata = {12'h0, h_r.addr};
				`FWSR_REG_DATA:   h_nxt.rdata = {24'h0, h_r.wdata};
				`FWSR_REG_STATUS: h_nxt.rdata = {28'h0, h_r.err_seen, !rb_level, h_r.res};
				`FWSR_REG_LAST:   h_nxt.rdata = {24'h0, h_r.last};
				default: begin
					h_nxt.rdata = 32'h0;
					h_nxt.rresp = `FWSR_RESP_SLVERR;
				end
			endcase
		end else if (h_r.rvalid && s_axi_rready_in) begin
			h_nxt.rvalid = 1'b0;
		end
		// Toggle-polling sequence on the flash
		unique case (h_r.st)
			fwsr_pkg::ST_IDLE: begin
				if (h_r.want_write) begin
					h_nxt.want_write = 1'b0;
					cyc_start        = 1'b1;
					cyc_write        = 1'b1;
					h_nxt.st         = fwsr_pkg::ST_WR;
				end else if (h_r.go) begin
					// Each poll starts over from the double read RQ20
					h_nxt.go       = 1'b0;
					h_nxt.err_seen = 1'b0;
					h_nxt.res      = fwsr_pkg::RES_BUSY;
					cyc_start      = 1'b1;
					h_nxt.st       = fwsr_pkg::ST_RD1;
				end
			end
			fwsr_pkg::ST_WR: begin
				if (cyc_done) begin
					h_nxt.st = fwsr_pkg::ST_IDLE;
				end
			end
			fwsr_pkg::ST_RD1: begin
				if (cyc_done) begin
					h_nxt.first = cyc_rdata;
					cyc_start   = 1'b1;
					h_nxt.st    = fwsr_pkg::ST_RD2;
				end
			end
			fwsr_pkg::ST_RD2: begin
				if (cyc_done) begin
					h_nxt.st = fwsr_pkg::ST_CMP;
				end
			end
			fwsr_pkg::ST_CMP: begin
				h_nxt.last = cyc_rdata;
				// Two reads compared before any verdict RQ16
				if (!toggled[`FWSR_BIT_TOG1]) begin
					h_nxt.res = fwsr_pkg::RES_PASS; // RQ17
					h_nxt.st  = fwsr_pkg::ST_DONE;
				end else if (cyc_rdata[`FWSR_BIT_ERR]) begin
					h_nxt.err_seen = 1'b1; // RQ18
					cyc_start      = 1'b1;
					h_nxt.st       = fwsr_pkg::ST_RD3;
				end else begin
					// Still busy without error: keep watching
					cyc_start = 1'b1;
					h_nxt.st  = fwsr_pkg::ST_RD1;
				end
			end
			fwsr_pkg::ST_RD3: begin
				if (cyc_done) begin
					h_nxt.first = cyc_rdata;
					cyc_start   = 1'b1;
					h_nxt.st    = fwsr_pkg::ST_RD4;
				end
			end
			fwsr_pkg::ST_RD4: begin
				if (cyc_done) begin
					h_nxt.st = fwsr_pkg::ST_CMP2;
				end
			end
			fwsr_pkg::ST_CMP2: begin
				h_nxt.last = cyc_rdata;
				if (toggled[`FWSR_BIT_TOG1]) begin
					// Failed: issue reset so array reads return RQ19
					h_nxt.res   = fwsr_pkg::RES_FAIL;
					h_nxt.wdata = `FWSR_RESET_CMD;
					cyc_start   = 1'b1;
					cyc_write   = 1'b1;
					cyc_wdata   = `FWSR_RESET_CMD;
					h_nxt.st    = fwsr_pkg::ST_WR;
				end else begin
					h_nxt.res = fwsr_pkg::RES_PASS; // RQ18
					h_nxt.st  = fwsr_pkg::ST_DONE;
				end
			end
			fwsr_pkg::ST_DONE: begin
				h_nxt.st = fwsr_pkg::ST_IDLE;
			end
			default: begin
				h_nxt.st = fwsr_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			h_r    <= '0;
			h_r.st <= fwsr_pkg::ST_IDLE;
		end else begin
			h_r <= h_nxt;
		end
	end
	assign flash_addr_out    = h_r.addr;
	assign s_axi_awready_out = !h_r.aw_got;
	assign s_axi_wready_out  = !h_r.w_got;
	assign s_axi_bvalid_out  = h_r.bvalid;
	assign s_axi_bresp_out   = h_r.bresp;
	assign s_axi_arready_out = !h_r.rvalid;
	assign s_axi_rvalid_out  = h_r.rvalid;
	assign s_axi_rdata_out   = h_r.rdata;
	assign s_axi_rresp_out   = h_r.rresp;
endmodule : fwsr_host

// ===== fwsr_host_assertions.sv
// Concurrent checks on the poller's flash strobes and register bus
`timescale 1ns/1ps
module fwsr_host_assertions (
	input wire logic        clock_in,
	input wire logic        rst_n_in,
	input wire logic        ce_n_out,
	input wire logic        oe_n_out,
	input wire logic        we_n_out,
	input wire logic        dq_oe_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_write_pulse;
		!we_n_out[*4] ##1 we_n_out;
	endsequence
	sequence s_read_hold;
		(!oe_n_out && !ce_n_out)[*4];
	endsequence
	chk_read_strobe: assert property ($fell(oe_n_out) |-> !ce_n_out && we_n_out)
		else $error("read strobe without chip select");
	chk_read_width: assert property ($fell(oe_n_out) |-> s_read_hold)
		else $error("read strobe too short");
	chk_write_width: assert property ($fell(we_n_out) |-> s_write_pulse)
		else $error("write strobe width wrong");
	chk_read_nodrive: assert property (!oe_n_out |-> !dq_oe_out)
		else $error("data driven during read");
	chk_write_drive: assert property (!we_n_out |-> dq_oe_out && !ce_n_out && oe_n_out)
		else $error("write without data drive");
	chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	chk_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	chk_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped");
endmodule : fwsr_host_assertions

// ===== fwsr_pkg.sv
// Types shared by the status poller modules
package fwsr_pkg;
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_RD1   = 9'h002,
		ST_RD2   = 9'h004,
		ST_CMP   = 9'h008,
		ST_RD3   = 9'h010,
		ST_RD4   = 9'h020,
		ST_CMP2  = 9'h040,
		ST_WR    = 9'h080,
		ST_DONE  = 9'h100
	} fwsr_state_t;
	typedef enum logic [1:0] {
		RES_BUSY = 2'h0,
		RES_PASS = 2'h1,
		RES_FAIL = 2'h2
	} fwsr_result_t;
endpackage : fwsr_pkg

// ===== fwsr_sync.sv
// Three-stage input synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
module fwsr_sync (
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	input  wire logic async_in,
	output logic      level_out
);
	typedef struct packed {
		logic [2:0] sh;
		logic       lv;
	} fwsr_sync_t;
	fwsr_sync_t s_r;
	fwsr_sync_t s_nxt;
	always_comb begin
		s_nxt    = s_r;
		s_nxt.sh = {s_r.sh[1:0], async_in};
		if (s_r.sh[1] == s_r.sh[2]) begin
			s_nxt.lv = s_r.sh[2];
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '{sh: 3'b111, lv: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign level_out = s_r.lv;
endmodule : fwsr_sync

// ===== tb_fwsr_host.sv
// Self-checking bench for the write-status poller
`timescale 1ns/1ps
module tb_fwsr_host;
	logic        clock_in = 0, rst_n_in = 0;
	logic [7:0]  awaddr = 0, araddr = 0, fdq, hdq, val;
	logic [31:0] wdata = 0, rdata, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe, rb_n;
	logic [1:0]  bresp, rresp, r;
	logic [19:0] faddr;
	int          error_cnt = 0, checks = 0, seed = 11953, i, exp_q[$];
	always #12.5 clock_in = ~clock_in;
	fwsr_host fwsr_host_i (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .flash_addr_out(faddr), .ce_n_out(ce_n), .oe_n_out(oe_n),
		.we_n_out(we_n), .dq_in(fdq), .dq_out(hdq), .dq_oe_out(dq_oe), .ready_busy_n_in(rb_n));
	fwsr_flash_model fwsr_flash_model_i (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
		.dq_in(hdq), .dq_out(fdq), .ready_busy_n_out(rb_n));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic timed_out;
		error_cnt++;
		$display("unexpected wait expected answer seen timeout");
		give_verdict();
	endtask : timed_out
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge clock_in);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 200; n++) begin
			@(posedge clock_in);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				rs = bresp;
				bready <= 0;
				return;
			end
		end
		timed_out();
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 200; n++) begin
			@(posedge clock_in);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				rready <= 0;
				return;
			end
		end
		timed_out();
	endtask : axi_rd
	// Flash writes outlive the register write, so wait on the busy bit
	task automatic wait_idle;
		logic [31:0] v;
		logic [1:0]  s;
		int          n;
		for (n = 0; n < 100; n++) begin
			axi_rd(8'h00, v, s);
			if (v[0] === 1'b0) return;
		end
		timed_out();
	endtask : wait_idle
	// Expected verdict comes from the mode the device was put in
	task automatic poll(input int md, input int n);
		if (md >= 0) begin
			fwsr_flash_model_i.mode = md;
			fwsr_flash_model_i.busy_left = n;
		end
		exp_q.push_back(md == 3 ? 2 : 1);
		axi_wr(8'h00, 32'h2, r);
		axi_wr(8'h00, 32'h1, r);
		for (i = 0; i < 100; i++) begin
			axi_rd(8'h0C, d, r);
			if (d[1:0] !== 2'b00) break;
		end
		if (i == 100) timed_out();
		check("result", d[1:0], exp_q.pop_front());
		wait_idle();
	endtask : poll
	initial begin
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1;
		axi_rd(8'h0C, d, r);
		check("status reset", d, 32'h0);
		axi_rd(8'h14, d, r);
		check("unmapped read", {r, d[29:0]}, 32'h80000000);
		axi_wr(8'h14, 32'h1, r);
		check("unmapped write", r, 2'b10);
		$display("test registers done");
		poll(0, 0);
		axi_rd(8'h10, d, r);
		check("idle last", d, 32'h5A);
		$display("test idle done");
		fwsr_flash_model_i.mode = 2;
		repeat (10) @(posedge clock_in);
		axi_rd(8'h0C, d, r);
		check("device busy", d[2], 1'b1);
		poll(-1, 0);
		fwsr_flash_model_i.busy_left = 4;
		axi_rd(8'h10, d, r);
		check("erase last", d, 32'h5A);
		$display("test erase done");
		poll(3, 0);
		check("error seen", d[3], 1'b1);
		check("reset sent", fwsr_flash_model_i.resets, 1);
		axi_rd(8'h10, d, r);
		check("fail last", d & 32'hA8, 32'h28);
		$display("test failure done");
		val = $random(seed);
		// The reset command byte would not start a program
		if (val == 8'hF0) val = 8'h0F;
		d = $random(seed) & 32'hFFFF;
		axi_wr(8'h04, d, r);
		check("flash address", faddr, d[19:0]);
		axi_wr(8'h08, {24'h0, val}, r);
		axi_wr(8'h00, 32'h4, r);
		wait_idle();
		check("written byte", fwsr_flash_model_i.last_w, val);
		poll(-1, 0);
		axi_rd(8'h10, d, r);
		check("program last", d, {24'h0, val});
		$display("test program done");
		axi_wr(8'h00, 32'h8, r);
		wait_idle();
		check("reset command", fwsr_flash_model_i.last_w, 32'hF0);
		check("reset count", fwsr_flash_model_i.resets, 2);
		$display("test reset command done");
		give_verdict();
	end
endmodule : tb_fwsr_host
bind fwsr_host fwsr_host_assertions fwsr_host_assertions_i (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out),
	.we_n_out(we_n_out), .dq_oe_out(dq_oe_out), .s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in));
